// ---- hw/toc_top.sv ----
// Purpose: 16-bit timer counter with three output compare channels
// Assumes: mclk 40 MHz, tmr_tick comes from a prescaler on mclk
// Notes: register access over plain 8-bit port, read data one cycle later
`timescale 1ns/1ps
`include "toc_consts.svh"

module toc_top
    import toc_pkg::*;
#(
    parameter int NCH = 3
) (
    input wire logic mclk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic cen, // clock enable, freezes all state when low
    input wire logic tmr_tick, // timer clock enable pulse from prescaler
    input wire toc_bus_s bus, // register port request
    input wire logic [NCH:0] irq_ack, // interrupt serviced: bit0 overflow, then channels
    output logic [7:0] rdata, // read data, valid the cycle after rd
    output logic [NCH:0] irq_req, // interrupt requests, same order as irq_ack
    output logic [NCH-1:0] pin_out, // pin value (waveform latch or port data)
    output logic [NCH-1:0] pin_oe // pin drive enable from direction bits
);

    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [15:0] counter_value;
    logic [15:0] capture_value;
    logic [7:0] temp_high;
    logic count_down;
    logic match_block;
    logic counter_overflow_flag;
    logic [NCH:0] irq_enable;
    logic [NCH-1:0] port_data;
    logic [NCH-1:0] output_pin_direction_bit;
    logic [NCH-1:0] compare_match_flag;
    logic [NCH-1:0] waveform_output_latch;
    logic [15:0] cmp_active [NCH];
    logic [15:0] cmp_buffer [NCH];

    wire logic [3:0] waveform_mode_select = {ctrl_b[`TOC_CTRLB_WGM_LSB +: 2], ctrl_a[`TOC_CTRLA_WGM_LSB +: 2]};
    wire logic [2:0] clock_source_select = ctrl_b[`TOC_CTRLB_CS_LSB +: 3];
    wire logic wr = cen & bus.wr;
    wire logic rd = cen & bus.rd;

    // counting follows the mode field alone
    toc_slope_e slope;
    toc_top_src_e top_src;
    logic [15:0] fixed_top;
    logic buf_at_bottom;
    always_comb begin
        slope = TOC_SLOPE_FAST;
        top_src = TOC_TOP_SRC_FIXED;
        fixed_top = `TOC_MAX;
        buf_at_bottom = 1'b0;
        case (waveform_mode_select)
            4'd0: begin
                slope = TOC_SLOPE_NONPWM;
                top_src = TOC_TOP_SRC_MAX;
            end
            4'd4: begin
                slope = TOC_SLOPE_NONPWM;
                top_src = TOC_TOP_SRC_CMPA;
            end
            4'd12: begin
                slope = TOC_SLOPE_NONPWM;
                top_src = TOC_TOP_SRC_CAP;
            end
            4'd1, 4'd5: fixed_top = `TOC_TOP_8BIT;
            4'd2, 4'd6: fixed_top = `TOC_TOP_9BIT;
            4'd3, 4'd7: fixed_top = `TOC_TOP_10BIT;
            4'd15: top_src = TOC_TOP_SRC_CMPA;
            4'd14: top_src = TOC_TOP_SRC_CAP;
            4'd9: begin
                top_src = TOC_TOP_SRC_CMPA;
                buf_at_bottom = 1'b1;
            end
            4'd11: top_src = TOC_TOP_SRC_CMPA;
            4'd8: begin
                top_src = TOC_TOP_SRC_CAP;
                buf_at_bottom = 1'b1;
            end
            4'd10: top_src = TOC_TOP_SRC_CAP;
            default: top_src = TOC_TOP_SRC_MAX;
        endcase
        // dual slope for the phase correct and the phase and frequency correct modes
        if (waveform_mode_select inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11}) begin
            slope = TOC_SLOPE_DUAL;
        end
    end

    wire logic [15:0] top_value = (top_src == TOC_TOP_SRC_CMPA) ? cmp_active[0] :
                                  (top_src == TOC_TOP_SRC_CAP) ? capture_value :
                                  (top_src == TOC_TOP_SRC_FIXED) ? fixed_top : `TOC_MAX;
    wire logic pwm_mode = (slope != TOC_SLOPE_NONPWM);
    wire logic buffered = pwm_mode;

    // one evaluation per tick; a stopped source gives no ticks
    wire logic tick = cen & tmr_tick & (clock_source_select != 3'd0);
    wire logic live = tick & ~match_block;
    // the TOP match is blocked too after a counter write, so a loaded TOP is passed over
    wire logic at_top = (counter_value == top_value) & ~match_block;
    wire logic at_bottom = (counter_value == `TOC_RST_WORD);

    // register port decode
    wire logic wr_ctrl_a = wr & (bus.addr == `TOC_REG_CTRL_A);
    wire logic wr_ctrl_b = wr & (bus.addr == `TOC_REG_CTRL_B);
    wire logic wr_force = wr & (bus.addr == `TOC_REG_FORCE);
    wire logic wr_cnt_l = wr & (bus.addr == `TOC_REG_CNT_L);
    wire logic wr_cap_l = wr & (bus.addr == `TOC_REG_CAP_L);
    wire logic wr_irq_en = wr & (bus.addr == `TOC_REG_IRQ_EN);
    wire logic wr_flags = wr & (bus.addr == `TOC_REG_FLAGS);
    wire logic wr_port_data = wr & (bus.addr == `TOC_REG_PORT_DATA);
    wire logic wr_port_dir = wr & (bus.addr == `TOC_REG_PORT_DIR);
    wire logic wr_high = wr & ((bus.addr == `TOC_REG_CNT_H) | (bus.addr == `TOC_REG_CAP_H) |
                               ((bus.addr >= `TOC_REG_CMP_L0) & ~bus.addr[0] &
                                (bus.addr < 5'(`TOC_REG_CMP_L0 + 2 * NCH))));
    wire logic rd_cnt_l = rd & (bus.addr == `TOC_REG_CNT_L);
    wire logic rd_cap_l = rd & (bus.addr == `TOC_REG_CAP_L);
    // capture register is writable only when it defines TOP
    wire logic cap_is_top = (top_src == TOC_TOP_SRC_CAP);

    // counter next value, cpu write first
    logic [15:0] next_counter_value;
    logic next_count_down;
    always_comb begin
        next_counter_value = counter_value;
        next_count_down = count_down;
        if (wr_cnt_l) begin
            next_counter_value = {temp_high, bus.wdata};
        end else if (tick) begin
            case (slope)
                TOC_SLOPE_DUAL: begin
                    if (!count_down && at_top) begin
                        next_count_down = 1'b1;
                        next_counter_value = counter_value - 16'h0001;
                    end else if (count_down && at_bottom) begin
                        next_count_down = 1'b0;
                        next_counter_value = counter_value + 16'h0001;
                    end else if (count_down) begin
                        next_counter_value = counter_value - 16'h0001;
                    end else begin
                        next_counter_value = counter_value + 16'h0001;
                    end
                end
                // single slope: clear after TOP, except in free running normal mode
                TOC_SLOPE_NONPWM, TOC_SLOPE_FAST: begin
                    next_count_down = 1'b0;
                    if (at_top && top_src != TOC_TOP_SRC_MAX) begin
                        next_counter_value = `TOC_RST_WORD;
                    end else begin
                        next_counter_value = counter_value + 16'h0001;
                    end
                end
                default: next_counter_value = counter_value;
            endcase
        end
    end

    // overflow: wrap to zero in non-PWM, TOP in fast, BOTTOM in dual slope
    wire logic ovf_event = tick & ((slope == TOC_SLOPE_NONPWM) ? (counter_value == `TOC_MAX) :
                                   (slope == TOC_SLOPE_FAST) ? at_top : (count_down & at_bottom));
    // buffer moves only on the tick where the counter turns, so no odd-length pulse
    wire logic buf_update = tick & ((slope == TOC_SLOPE_FAST) ? at_top :
                                    buf_at_bottom ? (count_down & at_bottom) : (~count_down & at_top));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_a <= `TOC_RST_BYTE;
            ctrl_b <= `TOC_RST_BYTE;
            counter_value <= `TOC_RST_WORD;
            count_down <= 1'b0;
            capture_value <= `TOC_RST_WORD;
            temp_high <= `TOC_RST_BYTE;
            match_block <= 1'b0;
            irq_enable <= '0;
            port_data <= '0;
            output_pin_direction_bit <= '0;
        end else if (cen) begin
            if (wr_ctrl_a) ctrl_a <= bus.wdata;
            if (wr_ctrl_b) ctrl_b <= bus.wdata;
            counter_value <= next_counter_value;
            count_down <= next_count_down;
            if (wr_cap_l && cap_is_top) capture_value <= {temp_high, bus.wdata};
            if (wr_high) begin
                temp_high <= bus.wdata;
            end else if (rd_cnt_l) begin
                temp_high <= counter_value[15:8];
            end else if (rd_cap_l) begin
                temp_high <= capture_value[15:8];
            end
            // block holds until the next timer cycle has passed, even while stopped
            if (wr_cnt_l) begin
                match_block <= 1'b1;
            end else if (tick) begin
                match_block <= 1'b0;
            end
            if (wr_irq_en) irq_enable <= bus.wdata[NCH:0];
            if (wr_port_data) port_data <= bus.wdata[NCH-1:0];
            if (wr_port_dir) output_pin_direction_bit <= bus.wdata[NCH-1:0];
        end
    end

    // set beats a same-cycle clear so no overflow is lost
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            counter_overflow_flag <= 1'b0;
        end else if (cen) begin
            if (ovf_event) begin
                counter_overflow_flag <= 1'b1;
            end else if (irq_ack[0] || (wr_flags && bus.wdata[`TOC_FLAG_OVF])) begin
                counter_overflow_flag <= 1'b0;
            end
        end
    end

    // per channel compare, flag and waveform latch
    logic [7:0] cmp_rd_byte [NCH];
    logic [NCH-1:0] cmp_rd_hit;
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            localparam logic [4:0] ADDR_L = 5'(`TOC_REG_CMP_L0 + 2 * ch);
            localparam logic [4:0] ADDR_H = 5'(`TOC_REG_CMP_H0 + 2 * ch);
            wire logic [1:0] output_action_select = ctrl_a[`TOC_CTRLA_ACT_MSB - 2 * ch -: 2];
            wire logic wr_low = wr & (bus.addr == ADDR_L);
            wire logic force_match_strobe = wr_force & bus.wdata[`TOC_FORCE_MSB - ch] & ~pwm_mode;
            wire logic equal = (counter_value == cmp_active[ch]);
            // one evaluation per tick, so a stopped counter cannot match every mclk
            wire logic match = live & equal;
            wire logic [15:0] cmp_view = buffered ? cmp_buffer[ch] : cmp_active[ch];
            wire logic flag_clr = irq_ack[ch+1] | (wr_flags & bus.wdata[`TOC_FLAG_CMP0 + ch]);
            logic next_latch;

            always_comb begin
                next_latch = waveform_output_latch[ch];
                case (slope)
                    TOC_SLOPE_NONPWM: begin
                        if (match || force_match_strobe) begin
                            case (output_action_select)
                                2'b01: next_latch = ~waveform_output_latch[ch];
                                2'b10: next_latch = 1'b0;
                                2'b11: next_latch = 1'b1;
                                default: next_latch = waveform_output_latch[ch];
                            endcase
                        end
                    end
                    TOC_SLOPE_FAST: begin
                        if (output_action_select[1]) begin
                            if (match) begin
                                next_latch = ~output_action_select[0];
                            end else if (tick && at_top) begin
                                next_latch = output_action_select[0];
                            end
                        end
                    end
                    TOC_SLOPE_DUAL: begin
                        if (output_action_select[1] && match) begin
                            next_latch = count_down ^ output_action_select[0];
                        end
                    end
                    default: next_latch = waveform_output_latch[ch];
                endcase
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    cmp_active[ch] <= `TOC_RST_WORD;
                    cmp_buffer[ch] <= `TOC_RST_WORD;
                    compare_match_flag[ch] <= 1'b0;
                    waveform_output_latch[ch] <= 1'b0;
                end else if (cen) begin
                    // in PWM modes the cpu only ever touches the buffer
                    if (wr_low && buffered) begin
                        cmp_buffer[ch] <= {temp_high, bus.wdata};
                    end
                    if (wr_low && !buffered) begin
                        cmp_active[ch] <= {temp_high, bus.wdata};
                    end else if (buffered && buf_update) begin
                        cmp_active[ch] <= cmp_buffer[ch];
                    end
                    // set on the tick edge closing the equal cycle; set beats clear
                    if (match) begin
                        compare_match_flag[ch] <= 1'b1;
                    end else if (flag_clr) begin
                        compare_match_flag[ch] <= 1'b0;
                    end
                    waveform_output_latch[ch] <= next_latch;
                end
            end

            // compare bytes read straight from the register, never via temp_high
            assign cmp_rd_hit[ch] = (bus.addr == ADDR_L) | (bus.addr == ADDR_H);
            assign cmp_rd_byte[ch] = (bus.addr == ADDR_L) ? cmp_view[7:0] : cmp_view[15:8];
        end
    endgenerate

    // read mux, unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = `TOC_RST_BYTE;
        case (bus.addr)
            `TOC_REG_CTRL_A: rd_mux = ctrl_a;
            `TOC_REG_CTRL_B: rd_mux = ctrl_b;
            `TOC_REG_CNT_L: rd_mux = counter_value[7:0];
            `TOC_REG_CNT_H: rd_mux = temp_high;
            `TOC_REG_CAP_L: rd_mux = capture_value[7:0];
            `TOC_REG_CAP_H: rd_mux = temp_high;
            `TOC_REG_IRQ_EN: rd_mux = 8'(irq_enable);
            `TOC_REG_FLAGS: rd_mux = 8'({compare_match_flag, counter_overflow_flag});
            `TOC_REG_PORT_DATA: rd_mux = 8'(port_data);
            `TOC_REG_PORT_DIR: rd_mux = 8'(output_pin_direction_bit);
            default: begin
                for (int i = 0; i < NCH; i++) begin
                    if (cmp_rd_hit[i]) rd_mux = cmp_rd_byte[i];
                end
            end
        endcase
    end

    // any nonzero action hands the pin to the latch; capture logic never sees it
    logic [NCH-1:0] next_pin_out;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            next_pin_out[i] = (ctrl_a[`TOC_CTRLA_ACT_MSB - 2 * i -: 2] != 2'b00) ?
                              waveform_output_latch[i] : port_data[i];
        end
    end

    // registered outputs: pins and requests follow their cause one cycle late
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= `TOC_RST_BYTE;
            irq_req <= '0;
            pin_out <= '0;
            pin_oe <= '0;
        end else if (cen) begin
            rdata <= rd ? rd_mux : `TOC_RST_BYTE;
            irq_req <= irq_enable & {compare_match_flag, counter_overflow_flag};
            pin_out <= next_pin_out;
            pin_oe <= output_pin_direction_bit;
        end
    end

endmodule

// ---- include/toc_consts.svh ----
// Purpose: constants of the 16-bit timer output compare unit
// Assumes: 8-bit register port, 5-bit register address
// Notes: offsets are register indices on the plain port
// Behaviour
// - each channel compares the full 16-bit counter against its compare value continuously.
// - a match sets the channel flag at the following timer clock cycle.
// - flag with irq enable requests interrupt; service or writing one clears it.
// - compare channel A can supply the counter TOP value.
// - compare value double buffered in PWM modes, direct in normal and clear modes.
// - buffered value moves to the active register only at TOP or BOTTOM.
// - cpu compare accesses reach the buffer when buffering, else the active register.
// - only cpu writes change compare values; reads bypass the shared high latch.
// - high byte goes to shared latch; low write loads both bytes together.
// - force strobe in non-PWM modes acts on output only, no flag, no clear.
// - a counter write blocks every match in the next timer clock cycle.
// - waveform output latch keeps its value across waveform mode changes.
// - output action bits act at the first match after the write, unbuffered.
// - system reset clears every waveform output latch to zero.
// - nonzero output action replaces port data; direction bit still gates the pin.
// - output action zero leaves the waveform latch unchanged on matches.
// - output action bits do not touch input capture logic.
// - counting depends on waveform mode only; action bits choose the output effect.
// - mode 0 counts up always and wraps from 0xFFFF to 0x0000.
// - normal mode sets overflow when counter becomes zero; service or software clears.
// - normal mode accepts counter writes at any time.
// - clock source select zero stops counting; cpu access still works.
// - cpu counter write wins over simultaneous clear or count.
`ifndef TOC_CONSTS_SVH
`define TOC_CONSTS_SVH

`define TOC_ADDR_W 5
`define TOC_REG_CTRL_A 5'h00
`define TOC_REG_CTRL_B 5'h01
`define TOC_REG_FORCE 5'h02
`define TOC_REG_CNT_L 5'h03
`define TOC_REG_CNT_H 5'h04
`define TOC_REG_CAP_L 5'h05
`define TOC_REG_CAP_H 5'h06
`define TOC_REG_IRQ_EN 5'h07
`define TOC_REG_FLAGS 5'h08
`define TOC_REG_PORT_DATA 5'h09
`define TOC_REG_PORT_DIR 5'h0A
`define TOC_REG_CMP_L0 5'h0B
`define TOC_REG_CMP_H0 5'h0C

`define TOC_CTRLA_WGM_LSB 0
`define TOC_CTRLA_ACT_MSB 7
`define TOC_CTRLB_CS_LSB 0
`define TOC_CTRLB_WGM_LSB 3
`define TOC_FORCE_MSB 7
`define TOC_FLAG_OVF 0
`define TOC_FLAG_CMP0 1

`define TOC_RST_BYTE 8'h00
`define TOC_RST_WORD 16'h0000
`define TOC_MAX 16'hFFFF
`define TOC_TOP_8BIT 16'h00FF
`define TOC_TOP_9BIT 16'h01FF
`define TOC_TOP_10BIT 16'h03FF

`endif

// ---- include/toc_pkg.sv ----
// Purpose: types of the timer output compare unit
// Assumes: used together with toc_consts.svh
// Notes: none
package toc_pkg;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } toc_bus_s;

    typedef enum logic [1:0] {
        TOC_SLOPE_NONPWM = 2'b00,
        TOC_SLOPE_FAST = 2'b01,
        TOC_SLOPE_DUAL = 2'b10
    } toc_slope_e;

    typedef enum logic [1:0] {
        TOC_TOP_SRC_MAX = 2'b00,
        TOC_TOP_SRC_FIXED = 2'b01,
        TOC_TOP_SRC_CMPA = 2'b10,
        TOC_TOP_SRC_CAP = 2'b11
    } toc_top_src_e;

endpackage

// ---- tb/toc_top_asserts.sv ----
// Purpose: port-level checks of the timer output compare unit
// Assumes: registered outputs lag their cause by one cycle
// Notes: bound to every toc_top instance
`timescale 1ns/1ps
`include "toc_consts.svh"
module toc_top_asserts
    import toc_pkg::*;
#(
    parameter int NCH = 3
) (
    input wire logic mclk, // system clock
    input wire logic rst, // async reset
    input wire logic cen, // clock enable
    input wire logic tmr_tick, // timer tick
    input wire toc_bus_s bus, // register request
    input wire logic [NCH:0] irq_ack, // interrupt serviced
    input wire logic [7:0] rdata, // read data
    input wire logic [NCH:0] irq_req, // interrupt requests
    input wire logic [NCH-1:0] pin_out, // pin value
    input wire logic [NCH-1:0] pin_oe // pin drive enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_reset_pins: assert property (
        disable iff (1'b0) $fell(rst) |-> pin_out == '0 && pin_oe == '0 && irq_req == '0)
        else $error("outputs not cleared by reset");
    chk_rdata_idle: assert property (
        cen && !bus.rd |=> rdata == 8'h00) else $error("read data without a read");
    chk_force_rd_zero: assert property (
        cen && bus.rd && bus.addr == `TOC_REG_FORCE |=> rdata == 8'h00) else $error("force byte not zero");
    chk_dir_to_oe: assert property (
        cen && bus.wr && bus.addr == `TOC_REG_PORT_DIR ##1 cen |=> pin_oe == $past(bus.wdata[NCH-1:0], 2))
        else $error("drive enable not from direction bits");
    chk_ack_clears_irq: assert property (
        cen && irq_ack == '1 && !tmr_tick ##1 cen |=> irq_req == '0) else $error("serviced request still up");
    chk_irq_needs_tick: assert property (
        $past(cen) && $past(cen, 2) && (irq_req & ~$past(irq_req)) != '0
        |-> $past(tmr_tick, 2) || ($past(bus.wr, 2) && $past(bus.addr, 2) == `TOC_REG_IRQ_EN))
        else $error("request rose without a timer tick");
    chk_pin_cause: assert property (
        $past(cen) && $past(cen, 2) && pin_out != $past(pin_out) |-> $past(tmr_tick, 2) || $past(bus.wr, 2))
        else $error("pin changed without match or write");
    chk_mode_keeps: assert property (
        cen && !tmr_tick && bus.wr && bus.addr == `TOC_REG_CTRL_B ##1 cen && !tmr_tick && !bus.wr
        |=> $stable(pin_out)) else $error("mode change moved the latch");
endmodule

bind toc_top toc_top_asserts #(.NCH(NCH)) chk_i (.mclk(mclk), .rst(rst), .cen(cen), .tmr_tick(tmr_tick), .bus(bus),
    .irq_ack(irq_ack), .rdata(rdata), .irq_req(irq_req), .pin_out(pin_out), .pin_oe(pin_oe));

// ---- tb/toc_cpu_model.sv ----
// Purpose: cpu side of the register port
// Assumes: tasks are entered just after a rising mclk edge
// Notes: an idle cycle follows each access so strobes never meet
`timescale 1ns/1ps
module toc_cpu_model
    import toc_pkg::*;
(
    input wire logic mclk, // system clock
    output toc_bus_s bus, // register request
    input wire logic [7:0] rdata // read data from the block
);
    initial bus = '0;
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        @(posedge mclk);
        d = rdata;
    endtask
    // high byte first so the low write lands both together
    // counter loads never use TOP in variable-TOP PWM nor BOTTOM downcounting
    task automatic wr16(input logic [4:0] hi, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(hi - 5'h01, v[7:0]);
    endtask
endmodule

// ---- tb/test_toc_top.sv ----
// Purpose: directed test of the timer output compare unit
// Assumes: channel A is bit 0 of the pins; cen held high throughout
// Notes: ticks are held only for short bursts so counts stay exact
`timescale 1ns/1ps
`include "toc_consts.svh"
module test_toc_top
    import toc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cen = 1'b1;
    logic tmr_tick = 1'b0;
    logic [3:0] irq_ack = 4'h0;
    toc_bus_s bus;
    logic [7:0] rdata;
    logic [3:0] irq_req;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [7:0] d;
    int error_cnt = 0;
    int samples_checked = 0;
    always #12.5 mclk = ~mclk;
    toc_top #(.NCH(3)) dut (.mclk(mclk), .rst(rst), .cen(cen), .tmr_tick(tmr_tick), .bus(bus), .irq_ack(irq_ack),
        .rdata(rdata), .irq_req(irq_req), .pin_out(pin_out), .pin_oe(pin_oe));
    toc_cpu_model cpu (.mclk(mclk), .bus(bus), .rdata(rdata));
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
        cpu.rd(a, d);
        chk(d, exp);
    endtask
    // one edge first so the registered pin has taken the new state
    task automatic chk_pin(input logic [2:0] exp);
        @(posedge mclk);
        chk({5'h00, pin_out}, {5'h00, exp});
    endtask
    task automatic run_until_irq(input int idx);
        int n;
        n = 0;
        tmr_tick <= 1'b1;
        while (irq_req[idx] !== 1'b1) begin
            @(posedge mclk);
            n++;
            if (n > 200) begin
                chk({7'h00, irq_req[idx]}, 8'h01);
                wrap_up();
            end
        end
        tmr_tick <= 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk_pin(3'b000);
        chk({4'h0, irq_req}, 8'h00);
        cpu.wr16(`TOC_REG_CMP_H0, 16'h1234);
        chk_rd(`TOC_REG_CMP_L0, 8'h34);
        chk_rd(`TOC_REG_CMP_H0, 8'h12);
        cpu.wr(`TOC_REG_CMP_H0, 8'h56);
        chk_rd(`TOC_REG_CMP_H0, 8'h12);
        chk_rd(5'h1F, 8'h00);
        cpu.wr16(`TOC_REG_CMP_H0, 16'h0012);
        cpu.wr16(`TOC_REG_CNT_H, 16'h0010);
        cpu.wr(`TOC_REG_IRQ_EN, 8'h02);
        cpu.wr(`TOC_REG_PORT_DIR, 8'h07);
        cpu.wr(`TOC_REG_CTRL_A, 8'h40);
        cpu.wr(`TOC_REG_CTRL_B, 8'h01);
        run_until_irq(1);
        chk({4'h0, irq_req}, 8'h02);
        chk_pin(3'b001);
        chk({5'h00, pin_oe}, 8'h07);
        chk_rd(`TOC_REG_FLAGS, 8'h02);
        irq_ack <= 4'hF;
        @(posedge mclk);
        irq_ack <= 4'h0;
        chk_rd(`TOC_REG_FLAGS, 8'h00);
        // counter loaded equal to compare: first tick must not match
        cpu.wr16(`TOC_REG_CNT_H, 16'h0012);
        tmr_tick <= 1'b1;
        repeat (2) @(posedge mclk);
        tmr_tick <= 1'b0;
        chk_rd(`TOC_REG_FLAGS, 8'h00);
        cpu.wr(`TOC_REG_CTRL_B, 8'h00);
        tmr_tick <= 1'b1;
        repeat (4) @(posedge mclk);
        tmr_tick <= 1'b0;
        chk_rd(`TOC_REG_CNT_L, 8'h14);
        chk_rd(`TOC_REG_CNT_H, 8'h00);
        cpu.wr(`TOC_REG_FORCE, 8'h80);
        chk_pin(3'b000);
        chk_rd(`TOC_REG_FLAGS, 8'h00);
        chk_rd(`TOC_REG_FORCE, 8'h00);
        cpu.wr(`TOC_REG_CTRL_A, 8'h00);
        cpu.wr(`TOC_REG_PORT_DATA, 8'h05);
        cpu.wr(`TOC_REG_FORCE, 8'h80);
        chk_pin(3'b101);
        cpu.wr(`TOC_REG_CTRL_A, 8'hC0);
        chk_pin(3'b100);
        cpu.wr(`TOC_REG_FORCE, 8'h80);
        chk_pin(3'b101);
        cpu.wr(`TOC_REG_CTRL_A, 8'hC1);
        cpu.wr(`TOC_REG_CTRL_B, 8'h08);
        chk_pin(3'b101);
        cpu.wr16(`TOC_REG_CMP_H0, 16'h0040);
        chk_rd(`TOC_REG_CMP_L0, 8'h40);
        // back to normal mode and run through the wrap; B and C match at zero
        cpu.wr(`TOC_REG_CTRL_A, 8'h00);
        cpu.wr(`TOC_REG_CTRL_B, 8'h01);
        cpu.wr16(`TOC_REG_CMP_H0, 16'h1000);
        cpu.wr(`TOC_REG_IRQ_EN, 8'h03);
        cpu.wr16(`TOC_REG_CNT_H, 16'hFFFE);
        run_until_irq(0);
        chk_rd(`TOC_REG_FLAGS, 8'h0D);
        cpu.wr(`TOC_REG_FLAGS, 8'h0D);
        chk_rd(`TOC_REG_FLAGS, 8'h00);
        cpu.rd(`TOC_REG_CNT_L, d);
        chk_rd(`TOC_REG_CNT_H, 8'h00);
        // fast PWM with channel A as TOP: the new compare waits in the buffer until TOP
        cpu.wr(`TOC_REG_CTRL_B, 8'h18);
        cpu.wr(`TOC_REG_CTRL_A, 8'h03);
        cpu.wr16(`TOC_REG_CMP_H0, 16'h0005);
        cpu.wr16(`TOC_REG_CNT_H, 16'h0FFE);
        cpu.wr(`TOC_REG_CTRL_B, 8'h19);
        run_until_irq(0);
        chk_rd(`TOC_REG_CNT_L, 8'h02);
        tmr_tick <= 1'b1;
        repeat (4) @(posedge mclk);
        tmr_tick <= 1'b0;
        chk_rd(`TOC_REG_CNT_L, 8'h00);
        // a counter write lands even on a ticking edge
        tmr_tick <= 1'b1;
        cpu.wr16(`TOC_REG_CNT_H, 16'h0100);
        tmr_tick <= 1'b0;
        chk_rd(`TOC_REG_CNT_L, 8'h01);
        wrap_up();
    end
endmodule
